// *** irhp_pkg.sv ***
// Package of constants and types for the infrared controller host port
package irhp_pkg;
	// ********************
	// Widths
	// ********************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int DEPTH = 16;
	// ********************
	// Reset levels of outputs
	// ********************
	localparam logic IRQ_IDLE = 1'h1;
	localparam logic REMOTE_TX_RST = 1'h0;
	localparam logic IR_TX_RST = 1'h0;
	localparam logic AUX_CTL_RST = 1'h0;
	localparam logic SHUTDOWN_RST = 1'h1;
	localparam logic [DATA_W-1:0] LOC_RST = 16'h0000;
	// ********************
	// Location indices of the host-visible store
	// ********************
	localparam logic [ADDR_W-1:0] IDX_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_LINK_IRQ = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_REMOTE_IRQ = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h3;
	// ********************
	// Control word field positions
	// ********************
	localparam int CTRL_REMOTE_EN = 0;
	localparam int CTRL_PIN_SEL = 1;
	localparam int CTRL_AUX = 2;
	localparam int CTRL_SHUTDOWN = 3;
	localparam int CTRL_LINK_IE = 4;
	localparam int CTRL_REMOTE_IE = 5;
	// ********************
	// Power states
	// ********************
	typedef enum logic [1:0] {
		IRHP_RUN = 2'b00,
		IRHP_WAIT = 2'b01
	} irhp_pwr_t;
endpackage : irhp_pkg

// *** irhp_bus_if.sv ***
// Interface carrying decoded host accesses between the port modules
interface irhp_bus_if;
	logic rd_req;
	logic wr_req;
	logic [irhp_pkg::ADDR_W-1:0] addr;
	logic [irhp_pkg::DATA_W-1:0] wdata;
	logic [irhp_pkg::DATA_W-1:0] rdata;
	modport decoder (output rd_req, output wr_req, output addr, output wdata, input rdata);
	modport store (input rd_req, input wr_req, input addr, input wdata, output rdata);
endinterface : irhp_bus_if

// *** irhp_strobe.sv ***
// Strobe decoder: turns select, read and write levels into access requests
module irhp_strobe (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host pins
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [irhp_pkg::ADDR_W-1:0] addr,
	input wire logic [irhp_pkg::DATA_W-1:0] data_in,
	input wire logic enable,
	// Decoded side
	irhp_bus_if.decoder bus,
	output logic rd_active
);
	// ********************
	// State
	// ********************
	typedef struct packed {
		logic wr_seen;
	} irhp_strb_t;
	irhp_strb_t s_q;
	irhp_strb_t s_d;
	logic sel;
	always_comb begin
		sel = !cs_n && enable; // RULE1
		s_d = s_q;
		s_d.wr_seen = sel && !wr_n && rd_n;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	// One write per strobe: capture on the falling edge of the write level
	// Both strobes low together is ignored; hosts must avoid it
	assign bus.wr_req = sel && !wr_n && rd_n && !s_q.wr_seen; // RULE3 RULE13
	assign bus.rd_req = sel && !rd_n && wr_n; // RULE2
	assign rd_active = bus.rd_req;
	assign bus.addr = addr;
	assign bus.wdata = data_in;
endmodule : irhp_strobe

// *** irhp_store.sv ***
// Register store of host-visible locations
module irhp_store #(
	parameter int DEPTH = irhp_pkg::DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Decoded access
	irhp_bus_if.store bus,
	// Event inputs
	input wire logic link_event,
	input wire logic remote_event,
	input wire logic [irhp_pkg::DATA_W-1:0] status_word,
	// Stored control
	output logic [irhp_pkg::DATA_W-1:0] ctrl,
	output logic link_pend,
	output logic remote_pend
);
	typedef struct packed {
		logic [DEPTH-1:0][irhp_pkg::DATA_W-1:0] loc;
		logic link_pend;
		logic remote_pend;
	} irhp_st_t;
	irhp_st_t s_q;
	irhp_st_t s_d;
	function automatic logic hit(input logic [irhp_pkg::ADDR_W-1:0] a,
		input logic [irhp_pkg::ADDR_W-1:0] idx);
		hit = (a == idx);
	endfunction : hit
	always_comb begin
		s_d = s_q;
		if (bus.wr_req) begin
			s_d.loc[bus.addr] = bus.wdata; // RULE3
		end
		// Writing one to a pending word clears it; a new event wins the clear
		if (bus.wr_req && hit(bus.addr, irhp_pkg::IDX_LINK_IRQ) && bus.wdata[0]) begin
			s_d.link_pend = 1'b0;
		end
		if (bus.wr_req && hit(bus.addr, irhp_pkg::IDX_REMOTE_IRQ) && bus.wdata[0]) begin
			s_d.remote_pend = 1'b0;
		end
		if (link_event) begin
			s_d.link_pend = 1'b1;
		end
		if (remote_event) begin
			s_d.remote_pend = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0; // RULE6
		end else begin
			s_q <= s_d;
		end
	end
	always_comb begin
		bus.rdata = s_q.loc[bus.addr];
		if (hit(bus.addr, irhp_pkg::IDX_LINK_IRQ)) begin
			bus.rdata = {{(irhp_pkg::DATA_W-1){1'b0}}, s_q.link_pend};
		end else if (hit(bus.addr, irhp_pkg::IDX_REMOTE_IRQ)) begin
			bus.rdata = {{(irhp_pkg::DATA_W-1){1'b0}}, s_q.remote_pend};
		end else if (hit(bus.addr, irhp_pkg::IDX_STATUS)) begin
			bus.rdata = status_word;
		end
	end
	assign ctrl = s_q.loc[irhp_pkg::IDX_CTRL];
	assign link_pend = s_q.link_pend;
	assign remote_pend = s_q.remote_pend;
endmodule : irhp_store

// *** irhp_top.sv ***
// Host pin port of the infrared controller
// Function
// RULE1 - Chip select is active low; strobes act only while it is low.
// RULE2 - Low read strobe during selected access drives read data on the bus.
// RULE3 - Low write strobe during selected access stores bus data at the address.
// RULE4 - Link interrupt output is high after reset, low on a link event; the code lowers it only while CTRL_LINK_IE is set.
// RULE5 - Remote interrupt output is high after reset, low on a remote event; the code lowers it only while CTRL_REMOTE_IE is set.
// RULE6 - Low reset initialises all register settings and internal state; the code's rst is active high.
// RULE7 - Low power-down enters waiting state with low current consumption.
// RULE8 - Host holds reset low after power-down until the oscillator settles; rst here is active high, so the bench holds it high.
// RULE9 - Remote output low after reset; carries remote when enabled and select low.
// RULE10 - Auxiliary control output is low after reset.
// RULE11 - Module shutdown output is high after reset; may stay unconnected.
// RULE12 - Main transmit low after reset; link when disabled, remote when both high.
// RULE13 - Host never asserts read and write together in one access.
module irhp_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host bus
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [irhp_pkg::ADDR_W-1:0] addr,
	input wire logic [irhp_pkg::DATA_W-1:0] data_in,
	output logic [irhp_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	// Power
	input wire logic power_down_n,
	// Function cores
	input wire logic link_event,
	input wire logic remote_event,
	input wire logic link_tx_bit,
	input wire logic remote_tx_bit,
	// Interrupts
	output logic link_irq_n,
	output logic remote_irq_n,
	// Transmit and module control
	output logic infrared_tx_out,
	output logic remote_tx_out,
	output logic aux_control_out,
	output logic module_shutdown_out,
	output logic low_power
);
	// ********************
	// State
	// ********************
	typedef struct packed {
		irhp_pkg::irhp_pwr_t pwr;
		logic [irhp_pkg::DATA_W-1:0] rdata;
		logic oe;
		logic link_irq_n;
		logic remote_irq_n;
		logic ir_tx;
		logic rc_tx;
		logic aux;
		logic shdn;
	} irhp_top_t;
	irhp_top_t s_q;
	irhp_top_t s_d;
	irhp_bus_if bus ();
	logic rd_active;
	logic [irhp_pkg::DATA_W-1:0] ctrl;
	logic link_pend;
	logic remote_pend;
	logic running;
	logic [irhp_pkg::DATA_W-1:0] status_word;
	logic remote_enable;
	logic pin_sel;
	// Bus is closed while waiting so a stray strobe cannot disturb settings
	assign running = (s_q.pwr == irhp_pkg::IRHP_RUN); // RULE7
	assign status_word = {{(irhp_pkg::DATA_W-2){1'b0}}, remote_pend, link_pend};
	irhp_strobe u_strobe (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.addr(addr),
		.data_in(data_in),
		.enable(running),
		.bus(bus.decoder),
		.rd_active(rd_active)
	);
	irhp_store #(
		.DEPTH(irhp_pkg::DEPTH)
	) u_store (
		.clk(clk),
		.rst(rst),
		.bus(bus.store),
		.link_event(link_event && running),
		.remote_event(remote_event && running),
		.status_word(status_word),
		.ctrl(ctrl),
		.link_pend(link_pend),
		.remote_pend(remote_pend)
	);
	assign remote_enable = ctrl[irhp_pkg::CTRL_REMOTE_EN];
	assign pin_sel = ctrl[irhp_pkg::CTRL_PIN_SEL];
	always_comb begin
		s_d = s_q;
		case (s_q.pwr)
			irhp_pkg::IRHP_RUN: begin
				if (!power_down_n) begin
					s_d.pwr = irhp_pkg::IRHP_WAIT; // RULE7
				end
			end
			irhp_pkg::IRHP_WAIT: begin
				// Leaving waiting needs a reset per the restart sequence
				s_d.pwr = irhp_pkg::IRHP_WAIT; // RULE8
			end
			default: begin
				s_d.pwr = irhp_pkg::IRHP_WAIT;
			end
		endcase
		s_d.oe = rd_active; // RULE2
		s_d.rdata = bus.rdata; // RULE2
		s_d.link_irq_n = !(link_pend && ctrl[irhp_pkg::CTRL_LINK_IE]); // RULE4
		s_d.remote_irq_n = !(remote_pend && ctrl[irhp_pkg::CTRL_REMOTE_IE]); // RULE5
		s_d.ir_tx = 1'b0;
		s_d.rc_tx = 1'b0;
		if (running) begin
			if (!remote_enable) begin
				s_d.ir_tx = link_tx_bit; // RULE12
			end else if (pin_sel) begin
				s_d.ir_tx = remote_tx_bit; // RULE12
			end else begin
				s_d.rc_tx = remote_tx_bit; // RULE9
			end
		end
		s_d.aux = ctrl[irhp_pkg::CTRL_AUX]; // RULE10
		// Reset word is zero, so shutdown is stored inverted to reset high
		s_d.shdn = !ctrl[irhp_pkg::CTRL_SHUTDOWN] || !running; // RULE11
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q.pwr <= irhp_pkg::IRHP_RUN; // RULE6
			s_q.rdata <= irhp_pkg::LOC_RST;
			s_q.oe <= 1'b0;
			s_q.link_irq_n <= irhp_pkg::IRQ_IDLE; // RULE4
			s_q.remote_irq_n <= irhp_pkg::IRQ_IDLE; // RULE5
			s_q.ir_tx <= irhp_pkg::IR_TX_RST; // RULE12
			s_q.rc_tx <= irhp_pkg::REMOTE_TX_RST; // RULE9
			s_q.aux <= irhp_pkg::AUX_CTL_RST; // RULE10
			s_q.shdn <= irhp_pkg::SHUTDOWN_RST; // RULE11
		end else begin
			s_q <= s_d;
		end
	end
	assign data_out = s_q.rdata;
	assign data_oe = s_q.oe;
	assign link_irq_n = s_q.link_irq_n;
	assign remote_irq_n = s_q.remote_irq_n;
	assign infrared_tx_out = s_q.ir_tx;
	assign remote_tx_out = s_q.rc_tx;
	assign aux_control_out = s_q.aux;
	assign module_shutdown_out = s_q.shdn;
	assign low_power = !running;
endmodule : irhp_top

// *** irhp_props.sv ***
// Checker of the infrared controller host port pins
module irhp_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [irhp_pkg::ADDR_W-1:0] addr,
	input wire logic [irhp_pkg::DATA_W-1:0] data_in,
	input wire logic data_oe,
	input wire logic power_down_n,
	input wire logic link_tx_bit,
	input wire logic remote_tx_bit,
	input wire logic link_irq_n,
	input wire logic remote_irq_n,
	input wire logic infrared_tx_out,
	input wire logic remote_tx_out,
	input wire logic aux_control_out,
	input wire logic module_shutdown_out,
	input wire logic low_power
);
	// ****
	// Shadow of the mode bits, from taken control writes
	// ****
	logic [1:0] mode_q;
	logic wr_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= 2'h0;
			wr_q <= 1'h0;
		end else begin
			wr_q <= !cs_n && !wr_n && rd_n;
			if (!cs_n && !wr_n && rd_n && !wr_q && !low_power && addr == irhp_pkg::IDX_CTRL) begin
				mode_q <= data_in[1:0];
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_idle_bus: assert property (cs_n |=> !data_oe) else $error("bus driven unselected");
	a_read_drive: assert property (!cs_n && !rd_n && wr_n && !low_power |=> data_oe)
		else $error("read not answered");
	a_strobe_clash: assert property (!rd_n && !wr_n |=> !data_oe) else $error("clash drove bus");
	a_reset_levels: assert property ($fell(rst) |->
		link_irq_n && remote_irq_n && !infrared_tx_out && !remote_tx_out && !aux_control_out
		&& module_shutdown_out && !low_power) else $error("bad reset level");
	a_wait_entry: assert property (!power_down_n |=> low_power) else $error("no wait");
	a_wait_holds: assert property (low_power |=> low_power) else $error("wait left");
	a_wait_quiet: assert property (low_power |=> !infrared_tx_out && !remote_tx_out
		&& module_shutdown_out) else $error("outputs active in wait");
	a_link_route: assert property (!low_power && !mode_q[0] && $stable(mode_q)
		|=> infrared_tx_out == $past(link_tx_bit)) else $error("link not routed");
	a_remote_route: assert property (!low_power && mode_q == 2'h1 && $stable(mode_q)
		|=> remote_tx_out == $past(remote_tx_bit)) else $error("remote not routed");
endmodule : irhp_props
bind irhp_top irhp_props u_props (.*);

// *** irhp_host.sv ***
// Host processor model driving the parallel bus of the port
module irhp_host (
	// Clock
	input wire logic clk,
	// Bus
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [irhp_pkg::ADDR_W-1:0] addr,
	output logic [irhp_pkg::DATA_W-1:0] data_in,
	input wire logic [irhp_pkg::DATA_W-1:0] data_out,
	input wire logic data_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n = 1'h1;
		rd_n = 1'h1;
		wr_n = 1'h1;
		addr = 4'h0;
		data_in = 16'h0000;
	end
	// ****
	// One word per strobe; op bit 0 lowers read, bit 1 lowers write
	// ****
	task automatic access(input logic [1:0] op, input logic [irhp_pkg::ADDR_W-1:0] a,
		input logic [irhp_pkg::DATA_W-1:0] d, output logic [irhp_pkg::DATA_W-1:0] q,
		output logic oe);
		@(posedge clk);
		#1;
		cs_n = 1'h0;
		rd_n = !op[0];
		wr_n = !op[1];
		addr = a;
		data_in = d;
		@(posedge clk);
		#1;
		// Answer is taken before anything on the bus moves
		q = data_out;
		oe = data_oe;
		cs_n = 1'h1;
		rd_n = 1'h1;
		wr_n = 1'h1;
		// Released lines show the inverse so a stale word cannot pass
		addr = ~a;
		data_in = ~d;
	endtask : access
endmodule : irhp_host

// *** test_irhp_top.sv ***
// Self-checking bench of the infrared controller host port
module test_irhp_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [1:0] op;
		logic [3:0] a;
		logic [15:0] d;
		logic [15:0] q;
	} irhp_row_t;
	irhp_row_t rows [9] = '{'{2'h2, 4'h5, 16'hA55A, 16'h0}, '{2'h2, 4'hF, 16'hFFFF, 16'h0},
		'{2'h2, 4'h3, 16'h1234, 16'h0}, '{2'h1, 4'h5, 16'h0, 16'hA55A},
		'{2'h1, 4'hF, 16'h0, 16'hFFFF}, '{2'h1, 4'h3, 16'h0, 16'h0},
		'{2'h3, 4'h5, 16'h0, 16'h0}, '{2'h1, 4'h5, 16'h0, 16'hA55A}, '{2'h1, 4'h4, 16'h0, 16'h0}};
	logic [2:0] mode [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
	logic [2:0] outs [4] = '{3'h4, 3'h2, 3'h4, 3'h5};
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic power_down_n = 1'h1;
	logic link_event = 1'h0;
	logic remote_event = 1'h0;
	logic link_tx_bit = 1'h1;
	logic remote_tx_bit = 1'h1;
	logic cs_n, rd_n, wr_n, data_oe, oe, link_irq_n, remote_irq_n, low_power;
	logic infrared_tx_out, remote_tx_out, aux_control_out, module_shutdown_out;
	logic [3:0] addr;
	logic [15:0] data_in, data_out, q;
	int err_count = 0;
	int checks = 0;
	int n;
	irhp_top dut (.*);
	irhp_host host (.*);
	always #12.5 clk = ~clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("%0d checks, %0d mismatches", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'h0;
		check({link_irq_n, remote_irq_n, infrared_tx_out, remote_tx_out, aux_control_out,
			module_shutdown_out, low_power, data_oe}, 16'h00C4);
		$display("reset test done");
		for (int i = 0; i < 9; i++) begin
			host.access(rows[i].op, rows[i].a, rows[i].d, q, oe);
			check({15'h0, oe}, {15'h0, rows[i].op == 2'h1});
			if (rows[i].op == 2'h1) begin
				check(q, rows[i].q);
			end
		end
		$display("access rows done");
		for (int i = 0; i < 4; i++) begin
			// Only the source that the mode should route is high, so a wrong route shows
			link_tx_bit = !mode[i][0];
			remote_tx_bit = mode[i][0];
			host.access(2'h2, irhp_pkg::IDX_CTRL, {13'h0, mode[i]}, q, oe);
			repeat (2) @(posedge clk);
			#1;
			check({13'h0, infrared_tx_out, remote_tx_out, aux_control_out}, {13'h0, outs[i]});
		end
		host.access(2'h2, irhp_pkg::IDX_CTRL, 16'h0008, q, oe);
		repeat (2) @(posedge clk);
		#1;
		check({14'h0, module_shutdown_out, aux_control_out}, 16'h0000);
		$display("routing test done");
		for (int i = 0; i < 2; i++) begin
			host.access(2'h2, irhp_pkg::IDX_CTRL, 16'h0010 << i, q, oe);
			link_event = (i == 0);
			remote_event = (i == 1);
			@(posedge clk);
			#1;
			link_event = 1'h0;
			remote_event = 1'h0;
			for (n = 0; n < 8 && {link_irq_n, remote_irq_n} == 2'h3; n++) begin
				@(posedge clk);
				#1;
			end
			if (n == 8) begin
				err_count++;
				summarize();
			end
			check({14'h0, link_irq_n, remote_irq_n}, {14'h0, i[0], !i[0]});
			host.access(2'h1, irhp_pkg::IDX_STATUS, 16'h0, q, oe);
			check(q, 16'h0001 << i);
			host.access(2'h2, irhp_pkg::IDX_LINK_IRQ + 4'(i), 16'h0001, q, oe);
			repeat (2) @(posedge clk);
			#1;
			check({14'h0, link_irq_n, remote_irq_n}, 16'h0003);
		end
		$display("interrupt test done");
		power_down_n = 1'h0;
		repeat (3) @(posedge clk);
		#1;
		check({13'h0, low_power, infrared_tx_out, module_shutdown_out}, 16'h0005);
		host.access(2'h1, 4'h5, 16'h0, q, oe);
		check({15'h0, oe}, 16'h0000);
		// Oscillator settling is shortened to 16 cycles to keep the run brief
		power_down_n = 1'h1;
		rst = 1'h1;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'h0;
		host.access(2'h1, 4'h5, 16'h0, q, oe);
		check({q[14:0], low_power}, 16'h0000);
		$display("power test done");
		summarize();
	end
endmodule : test_irhp_top
